// file: dv/cmpc_board.sv
`timescale 1ns/1ps
module cmpc_board (
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe,
  input wire logic [3:0] ext,
  output logic [3:0] pinLvl
);
  // Board level shows only where the device lets go, so a stray drive is seen
  assign pinLvl = (devOut & devOe) | (ext & ~devOe);
endmodule

// file: dv/cmpc_pin_ctrl_properties.sv
`timescale 1ns/1ps
module cmpc_pin_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic spiMode,
  input wire logic [3:0] pinOneFunc,
  input wire logic [3:0] pinTwoFunc,
  input wire logic pinOneCont,
  input wire logic pinOneOutLevel,
  input wire logic [1:0] sdaFunc,
  input wire logic sdaOutLevel,
  input wire logic multiThreeAltData,
  input wire logic multiTwoOutEn,
  input wire logic multiTwoOutLevel,
  input wire logic [3:0] irqEvents,
  input wire logic general_pin_one_in,
  input wire logic general_pin_two_in,
  input wire logic multi_pin_zero_in,
  input wire logic multi_pin_three_in,
  input wire logic general_pin_one_out,
  input wire logic general_pin_one_oe,
  input wire logic sdaGpOut,
  input wire logic sdaGpOe,
  input wire logic sclGpOe,
  input wire logic multi_pin_two_out,
  input wire logic multi_pin_two_oe,
  input wire logic pinOneInLevel,
  input wire logic pinTwoInLevel,
  input wire logic multiZeroInLevel,
  input wire logic altDataIn
);
  int hiCnt;
  // Counter stands in for a repetition far beyond what the tools unroll
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hiCnt <= 0;
    end else begin
      hiCnt <= general_pin_one_out ? hiCnt + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_one_gp_out: assert property (
    pinOneFunc == cmpc_pkg::FN_GP_OUT |=>
    general_pin_one_oe && general_pin_one_out == $past(pinOneOutLevel)) else $error("pin one out");
  a_one_gp_in: assert property (
    pinOneFunc == cmpc_pkg::FN_GP_IN |=> pinOneInLevel == $past(general_pin_one_in))
    else $error("pin one level");
  a_two_gp_in: assert property (
    pinTwoFunc == cmpc_pkg::FN_GP_IN |=> pinTwoInLevel == $past(general_pin_two_in))
    else $error("pin two level");
  a_i2c_ctrl_kept: assert property (!spiMode |=> !sdaGpOe && !sclGpOe)
    else $error("control pin driven");
  a_spi_sda_out: assert property (
    spiMode && sdaFunc == cmpc_pkg::SFN_GP_OUT |=> sdaGpOe && sdaGpOut == $past(sdaOutLevel))
    else $error("data pin out");
  a_spi_multi_off: assert property (
    spiMode |=> !multi_pin_two_oe && !altDataIn && !multiZeroInLevel) else $error("multi pin on");
  a_alt_data_in: assert property (
    !spiMode && multiThreeAltData |=> altDataIn == $past(multi_pin_three_in))
    else $error("alt data");
  a_multi_two_out: assert property (
    !spiMode && multiTwoOutEn |=> multi_pin_two_oe ##0 multi_pin_two_out == $past(multiTwoOutLevel))
    else $error("multi two out");
  a_multi_zero_lvl: assert property (
    !spiMode |=> multiZeroInLevel == $past(multi_pin_zero_in)) else $error("multi zero level");
  a_irq_start: assert property (
    pinOneFunc == cmpc_pkg::FN_IRQ_SHORT && !pinOneCont && $rose(irqEvents[0])
    && !general_pin_one_out |-> ##2 general_pin_one_out) else $error("irq late");
  a_pulse_width: assert property (
    $fell(general_pin_one_out) && $past(pinOneFunc, 2) == cmpc_pkg::FN_IRQ_SHORT
    |-> hiCnt == cmpc_pkg::PULSE_CYC) else $error("pulse width");
  c_irq: cover property ($rose(general_pin_one_out) && pinOneFunc == cmpc_pkg::FN_IRQ_SHORT);
  c_spi_gp: cover property (spiMode && sdaGpOe);
  c_i2c_multi: cover property (!spiMode && multi_pin_two_oe);
endmodule
bind cmpc_pin_ctrl cmpc_pin_ctrl_chk chk (.*);

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, rst_b = 0, spiMode = 0, pinOneCont = 0, pinTwoCont = 0;
  logic pinOneOutLevel = 0, pinTwoOutLevel = 0, sdaOutLevel = 0, sclOutLevel = 0;
  logic multiThreeAltData = 0, multiTwoOutEn = 0, multiTwoOutLevel = 0;
  logic adcWclk = 0, clkOut = 0, altWclk = 0, altBclk = 0, dmicClk = 0;
  logic multi_pin_zero_in = 0, multi_pin_one_in = 0, multi_pin_three_in = 0;
  logic [3:0] pinOneFunc = 0, pinTwoFunc = 0, irqEvents = 0, ext = 0;
  logic [1:0] sdaFunc = 0, sclFunc = 0;
  logic general_pin_one_in, general_pin_two_in, sdaIn, sclIn;
  logic general_pin_one_out, general_pin_one_oe, general_pin_two_out, general_pin_two_oe;
  logic sdaGpOut, sdaGpOe, sclGpOut, sclGpOe, multi_pin_two_out, multi_pin_two_oe;
  logic pinOneInLevel, pinTwoInLevel, sdaInLevel, sclInLevel, altDataIn;
  logic multiZeroInLevel, multiOneInLevel, multiThreeInLevel;
  int n_errors = 0, compares = 0, cyc = 0;
  cmpc_pin_ctrl dut (.*);
  cmpc_board board (
    .devOut({sclGpOut, sdaGpOut, general_pin_two_out, general_pin_one_out}),
    .devOe({sclGpOe, sdaGpOe, general_pin_two_oe, general_pin_one_oe}), .ext(ext),
    .pinLvl({sclIn, sdaIn, general_pin_two_in, general_pin_one_in}));
  initial forever #12.5 clk_sys = ~clk_sys;
  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Single pulse takes 80k cycles, so the ceiling sits about 15k cycles above the whole run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task go(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task t_funcs;
    logic [3:0] codes [4];
    codes = '{cmpc_pkg::FN_ADC_WCLK, cmpc_pkg::FN_CLK_OUT, cmpc_pkg::FN_ALT_WCLK,
      cmpc_pkg::FN_DMIC_CLK};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      pinOneFunc <= codes[k];
      {dmicClk, altWclk, clkOut, adcWclk} <= 4'h1 << k;
      pinTwoFunc <= cmpc_pkg::FN_ALT_BCLK;
      altBclk <= k[0];
      go(2);
      chk(general_pin_one_out, 1);
      chk(general_pin_one_oe, 1);
      chk(general_pin_two_out, k[0]);
      chk(general_pin_two_oe, 1);
    end
  endtask
  task t_gpio;
    logic v;
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      @(posedge clk_sys);
      pinOneFunc <= cmpc_pkg::FN_GP_OUT;
      pinTwoFunc <= cmpc_pkg::FN_GP_IN;
      pinOneOutLevel <= v;
      ext <= {2'h0, ~v, v};
      go(2);
      chk(general_pin_one_out, v);
      chk(pinTwoInLevel, !v);
      @(posedge clk_sys);
      pinOneFunc <= cmpc_pkg::FN_GP_IN;
      pinTwoFunc <= cmpc_pkg::FN_GP_OUT;
      pinTwoOutLevel <= v;
      ext <= {2'h0, v, ~v};
      go(2);
      chk(pinOneInLevel, !v);
      chk(general_pin_two_out, v);
    end
  endtask
  task t_ctrl;
    @(posedge clk_sys);
    spiMode <= 1;
    sdaFunc <= cmpc_pkg::SFN_GP_OUT;
    sclFunc <= cmpc_pkg::SFN_GP_IN;
    sdaOutLevel <= 1;
    ext <= 4'h8;
    multiTwoOutEn <= 1;
    multiTwoOutLevel <= 1;
    go(2);
    chk(sdaGpOut, 1);
    chk(sdaGpOe, 1);
    chk(sclInLevel, 1);
    chk(multi_pin_two_oe, 0);
    @(posedge clk_sys);
    sdaFunc <= cmpc_pkg::SFN_GP_IN;
    sclFunc <= cmpc_pkg::SFN_GP_OUT;
    sclOutLevel <= 1;
    ext <= 4'h4;
    go(2);
    chk(sdaInLevel, 1);
    chk(sclGpOut, 1);
    @(posedge clk_sys);
    spiMode <= 0;
    go(2);
    chk(sclGpOe, 0);
    chk(sdaInLevel, 0);
    chk(multi_pin_two_oe, 1);
    chk(multi_pin_two_out, 1);
  endtask
  task t_multi;
    @(posedge clk_sys);
    multiThreeAltData <= 1;
    multi_pin_three_in <= 1;
    multi_pin_zero_in <= 1;
    multiTwoOutLevel <= 0;
    go(2);
    chk(altDataIn, 1);
    chk(multi_pin_two_out, 0);
    chk(multiZeroInLevel, 1);
    chk(multiOneInLevel, 0);
    @(posedge clk_sys);
    multiThreeAltData <= 0;
    multi_pin_one_in <= 1;
    go(2);
    chk(multiThreeInLevel, 1);
    chk(multiOneInLevel, 1);
    @(posedge clk_sys);
    spiMode <= 1;
    go(2);
    chk(multiZeroInLevel, 0);
  endtask
  task t_irq;
    int n;
    @(posedge clk_sys);
    pinOneFunc <= cmpc_pkg::FN_IRQ_SHORT;
    @(posedge clk_sys);
    irqEvents <= 4'h1;
    go(3);
    chk(general_pin_one_out, 1);
    n = 1;
    // Event drops and rises again mid-pulse; the pulse must not restart
    while (general_pin_one_out === 1'b1 && n < 90000) begin
      @(posedge clk_sys);
      if (n == 100) irqEvents <= 4'h0;
      if (n == 200) irqEvents <= 4'h1;
      #1;
      n++;
    end
    chk(n, cmpc_pkg::PULSE_CYC);
    go(4);
    chk(general_pin_one_out, 0);
  endtask
  task t_irq_codes;
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_sys);
      pinTwoFunc <= cmpc_pkg::FN_IRQ_SHORT + 4'(k);
      pinTwoCont <= k[0];
      irqEvents <= 4'h1 << k;
      go(3);
      chk(general_pin_two_out, 1);
      @(posedge clk_sys);
      rst_b <= 0;
      go(2);
      chk(general_pin_two_out, 0);
      @(posedge clk_sys);
      rst_b <= 1;
      irqEvents <= 4'h0;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1;
    t_funcs;
    t_gpio;
    t_ctrl;
    t_multi;
    t_irq;
    t_irq_codes;
    tally_and_finish;
  end
endmodule

// file: logic/cmpc_irq_if.sv
`timescale 1ns/1ps
interface cmpc_irq_if;
  logic [3:0] func;
  logic contMode;
  logic [3:0] events;
  logic pulse;
  modport ctrl(output func, output contMode, output events, input pulse);
  modport gen(input func, input contMode, input events, output pulse);
endinterface

// file: logic/cmpc_irq_pulse.sv
`timescale 1ns/1ps
module cmpc_irq_pulse #(
  parameter int PULSE_CYC = cmpc_pkg::PULSE_CYC,
  parameter int PERIOD_CYC = cmpc_pkg::TRAIN_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  cmpc_irq_if.gen irq
);
  cmpc_pkg::cmpc_irq_state_t state;
  logic [cmpc_pkg::CNT_W-1:0] cnt;
  logic [3:0] eventPrev;
  logic evSel;
  logic evSelPrev;
  logic evRise;

  always_comb begin
    evSel = 1'b0;
    evSelPrev = 1'b0;
    unique case (irq.func)
      cmpc_pkg::FN_IRQ_SHORT: begin
        evSel = irq.events[0];
        evSelPrev = eventPrev[0];
      end
      cmpc_pkg::FN_IRQ_AGC_NOISE: begin
        evSel = irq.events[1];
        evSelPrev = eventPrev[1];
      end
      cmpc_pkg::FN_IRQ_BUTTON: begin
        evSel = irq.events[2];
        evSelPrev = eventPrev[2];
      end
      cmpc_pkg::FN_IRQ_HEADSET: begin
        evSel = irq.events[3];
        evSelPrev = eventPrev[3];
      end
      default: begin
        evSel = 1'b0;
        evSelPrev = 1'b0;
      end
    endcase
  end

  // Edge on the selected event starts a pulse; other standing events must not mask it
  assign evRise = evSel & ~evSelPrev;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      eventPrev <= 4'h0;
    end else begin
      eventPrev <= irq.events;
    end
  end

  // Widths counted on the system clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= cmpc_pkg::CMPC_IDLE;
      cnt <= cmpc_pkg::RST_CNT;
    end else begin
      unique case (state)
        cmpc_pkg::CMPC_IDLE: begin
          if (evRise) begin
            state <= cmpc_pkg::CMPC_HIGH;
            cnt <= cmpc_pkg::RST_CNT;
          end
        end
        cmpc_pkg::CMPC_HIGH: begin
          if (cnt == cmpc_pkg::CNT_W'(PULSE_CYC - 1)) begin
            cnt <= cmpc_pkg::RST_CNT;
            state <= irq.contMode ? cmpc_pkg::CMPC_LOW : cmpc_pkg::CMPC_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        cmpc_pkg::CMPC_LOW: begin
          // Train stops once the event goes away
          if (!evSel || !irq.contMode) begin
            state <= cmpc_pkg::CMPC_IDLE;
          end else if (cnt == cmpc_pkg::CNT_W'(PERIOD_CYC - PULSE_CYC - 1)) begin
            cnt <= cmpc_pkg::RST_CNT;
            state <= cmpc_pkg::CMPC_HIGH;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= cmpc_pkg::CMPC_IDLE;
      endcase
    end
  end

  assign irq.pulse = (state == cmpc_pkg::CMPC_HIGH);
endmodule

// file: logic/cmpc_pin_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Pin one selects word clock, clock out, four interrupts, alt clock, mic clock, GPIO.
// - A general-purpose input pin shows its level in a status bit.
// - A general-purpose output pin drives its output-level control bit.
// - Single-pulse interrupt mode gives one 2 ms pulse per event.
// - Continuous mode gives a repeating pulse train while the event stands.
// - Pin two offers alt audio, interrupts, mic and GPIO like pin one.
// - In I2C mode the data and clock control pins stay on the bus.
// - In SPI mode both control pins may be GPIO input or output.
// - In SPI mode the multifunction pins carry SPI and lose other functions.
// - In I2C mode multifunction pin three is GPIO input or alt data input.
// - In I2C mode multifunction pin two is disabled or a driven output.
// - In I2C mode pins zero, one and three report their levels; pin three reports zero while it is alt data input.
module cmpc_pin_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic spiMode,
  input wire logic [3:0] pinOneFunc,
  input wire logic [3:0] pinTwoFunc,
  input wire logic pinOneCont,
  input wire logic pinTwoCont,
  input wire logic pinOneOutLevel,
  input wire logic pinTwoOutLevel,
  input wire logic [1:0] sdaFunc,
  input wire logic [1:0] sclFunc,
  input wire logic sdaOutLevel,
  input wire logic sclOutLevel,
  input wire logic multiThreeAltData,
  input wire logic multiTwoOutEn,
  input wire logic multiTwoOutLevel,
  input wire logic [3:0] irqEvents,
  input wire logic adcWclk,
  input wire logic clkOut,
  input wire logic altWclk,
  input wire logic altBclk,
  input wire logic dmicClk,
  input wire logic general_pin_one_in,
  input wire logic general_pin_two_in,
  input wire logic sdaIn,
  input wire logic sclIn,
  input wire logic multi_pin_zero_in,
  input wire logic multi_pin_one_in,
  input wire logic multi_pin_three_in,
  output logic general_pin_one_out,
  output logic general_pin_one_oe,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  output logic sdaGpOut,
  output logic sdaGpOe,
  output logic sclGpOut,
  output logic sclGpOe,
  output logic multi_pin_two_out,
  output logic multi_pin_two_oe,
  output logic pinOneInLevel,
  output logic pinTwoInLevel,
  output logic sdaInLevel,
  output logic sclInLevel,
  output logic multiZeroInLevel,
  output logic multiOneInLevel,
  output logic multiThreeInLevel,
  output logic altDataIn
);
  cmpc_irq_if irqOne();
  cmpc_irq_if irqTwo();
  logic next_oneOut;
  logic next_oneOe;
  logic next_twoOut;
  logic next_twoOe;

  assign irqOne.func = pinOneFunc;
  assign irqOne.contMode = pinOneCont;
  assign irqOne.events = irqEvents;
  assign irqTwo.func = pinTwoFunc;
  assign irqTwo.contMode = pinTwoCont;
  assign irqTwo.events = irqEvents;

  cmpc_irq_pulse uIrqOne (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .irq(irqOne.gen)
  );

  cmpc_irq_pulse uIrqTwo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .irq(irqTwo.gen)
  );

  // Pin one function mux
  always_comb begin
    next_oneOut = 1'b0;
    next_oneOe = 1'b1;
    unique case (pinOneFunc)
      cmpc_pkg::FN_ADC_WCLK: next_oneOut = adcWclk;
      cmpc_pkg::FN_CLK_OUT: next_oneOut = clkOut;
      cmpc_pkg::FN_IRQ_SHORT,
      cmpc_pkg::FN_IRQ_AGC_NOISE,
      cmpc_pkg::FN_IRQ_BUTTON,
      cmpc_pkg::FN_IRQ_HEADSET: next_oneOut = irqOne.pulse;
      cmpc_pkg::FN_ALT_WCLK: next_oneOut = altWclk;
      cmpc_pkg::FN_DMIC_CLK: next_oneOut = dmicClk;
      cmpc_pkg::FN_GP_OUT: next_oneOut = pinOneOutLevel;
      default: next_oneOe = 1'b0;
    endcase
  end

  // Pin two: alt bus clock, interrupts, mic clock and GPIO
  always_comb begin
    next_twoOut = 1'b0;
    next_twoOe = 1'b1;
    unique case (pinTwoFunc)
      cmpc_pkg::FN_ALT_BCLK: next_twoOut = altBclk;
      cmpc_pkg::FN_IRQ_SHORT,
      cmpc_pkg::FN_IRQ_AGC_NOISE,
      cmpc_pkg::FN_IRQ_BUTTON,
      cmpc_pkg::FN_IRQ_HEADSET: next_twoOut = irqTwo.pulse;
      cmpc_pkg::FN_DMIC_CLK: next_twoOut = dmicClk;
      cmpc_pkg::FN_GP_OUT: next_twoOut = pinTwoOutLevel;
      default: next_twoOe = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      general_pin_one_out <= 1'b0;
      general_pin_one_oe <= 1'b0;
      general_pin_two_out <= 1'b0;
      general_pin_two_oe <= 1'b0;
    end else begin
      general_pin_one_out <= next_oneOut;
      general_pin_one_oe <= next_oneOe;
      general_pin_two_out <= next_twoOut;
      general_pin_two_oe <= next_twoOe;
    end
  end

  // Status bits hold zero unless the pin is a general-purpose input
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pinOneInLevel <= 1'b0;
      pinTwoInLevel <= 1'b0;
    end else begin
      pinOneInLevel <= (pinOneFunc == cmpc_pkg::FN_GP_IN) & general_pin_one_in;
      pinTwoInLevel <= (pinTwoFunc == cmpc_pkg::FN_GP_IN) & general_pin_two_in;
    end
  end

  // Control pins are lent to GPIO only in SPI mode; in I2C the bus owns them
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sdaGpOut <= 1'b0;
      sdaGpOe <= 1'b0;
      sclGpOut <= 1'b0;
      sclGpOe <= 1'b0;
      sdaInLevel <= 1'b0;
      sclInLevel <= 1'b0;
    end else begin
      sdaGpOe <= spiMode & (sdaFunc == cmpc_pkg::SFN_GP_OUT);
      sclGpOe <= spiMode & (sclFunc == cmpc_pkg::SFN_GP_OUT);
      sdaGpOut <= spiMode & sdaOutLevel;
      sclGpOut <= spiMode & sclOutLevel;
      sdaInLevel <= spiMode & (sdaFunc == cmpc_pkg::SFN_GP_IN) & sdaIn;
      sclInLevel <= spiMode & (sclFunc == cmpc_pkg::SFN_GP_IN) & sclIn;
    end
  end

  // Multifunction pins are SPI signals in SPI mode, so all extras go quiet
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      multi_pin_two_out <= 1'b0;
      multi_pin_two_oe <= 1'b0;
      multiZeroInLevel <= 1'b0;
      multiOneInLevel <= 1'b0;
      multiThreeInLevel <= 1'b0;
      altDataIn <= 1'b0;
    end else begin
      multi_pin_two_oe <= ~spiMode & multiTwoOutEn;
      multi_pin_two_out <= ~spiMode & multiTwoOutEn & multiTwoOutLevel;
      multiZeroInLevel <= ~spiMode & multi_pin_zero_in;
      multiOneInLevel <= ~spiMode & multi_pin_one_in;
      multiThreeInLevel <= ~spiMode & ~multiThreeAltData & multi_pin_three_in;
      altDataIn <= ~spiMode & multiThreeAltData & multi_pin_three_in;
    end
  end
endmodule

// file: logic/cmpc_pkg.sv
package cmpc_pkg;
  // General pin function codes
  localparam logic [3:0] FN_DISABLED = 4'h0;
  localparam logic [3:0] FN_ADC_WCLK = 4'h1;
  localparam logic [3:0] FN_CLK_OUT = 4'h2;
  localparam logic [3:0] FN_IRQ_SHORT = 4'h3;
  localparam logic [3:0] FN_IRQ_AGC_NOISE = 4'h4;
  localparam logic [3:0] FN_IRQ_BUTTON = 4'h5;
  localparam logic [3:0] FN_IRQ_HEADSET = 4'h6;
  localparam logic [3:0] FN_ALT_WCLK = 4'h7;
  localparam logic [3:0] FN_DMIC_CLK = 4'h8;
  localparam logic [3:0] FN_GP_IN = 4'h9;
  localparam logic [3:0] FN_GP_OUT = 4'ha;
  localparam logic [3:0] FN_ALT_BCLK = 4'hb;
  // Serial control pin function codes
  localparam logic [1:0] SFN_DISABLED = 2'h0;
  localparam logic [1:0] SFN_GP_IN = 2'h1;
  localparam logic [1:0] SFN_GP_OUT = 2'h2;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int PULSE_US = 2000;
  localparam int PULSE_CYC = (CLK_HZ / 1000000) * PULSE_US;
  localparam int TRAIN_PERIOD_US = 4000;
  localparam int TRAIN_PERIOD_CYC = (CLK_HZ / 1000000) * TRAIN_PERIOD_US;
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] RST_CNT = 18'h00000;
  typedef enum logic [1:0] {
    CMPC_IDLE = 2'b00,
    CMPC_HIGH = 2'b01,
    CMPC_LOW = 2'b10
  } cmpc_irq_state_t;
endpackage
